// ### hdl/otpb_bank.sv
// Trace, user data and lock/CRC register bank of the OTP area, with array CRC watch.
// Assumes the serial front end presents one byte access at a time on the request port,
// and that the OTP controller pulses the commit and loads factory bytes after boot.
`timescale 1ns/100ps

module otpb_bank
    import otpb_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_init_complete,
    input  wire logic       i_req,
    input  wire logic       i_wr,
    input  wire logic [7:0] i_addr,
    input  wire logic [7:0] i_wdata,
    output logic            o_rsp_valid,
    output logic [7:0]      o_rsp_data,
    input  wire logic       i_otp_commit,
    input  wire logic       i_fact_wr,
    input  wire logic [7:0] i_fact_addr,
    input  wire logic [7:0] i_fact_data,
    output logic [3:0]      o_fact_trace_crc,
    output logic            o_user_crc_err,
    output logic            o_array_crc_err
);

    typedef struct packed {
        logic [OTPB_USER_BYTES-1:0][7:0] user;
        logic [7:0]                      ulock;
        logic [OTPB_TRACE_N-1:0][7:0]    trace;
        logic [OTPB_FLOCK_N-1:0][7:0]    flock;
        logic                            rsp_valid;
        logic [7:0]                      rsp_data;
        logic [3:0]                      trace_crc;
        logic                            user_err;
        logic [3:0]                      ref_crc;
        logic                            ref_ok;
        logic                            arr_err;
    } otpb_state_t;

    otpb_state_t st_q;
    otpb_state_t st_d;
    logic [1:0]  rst_sync_q;
    logic        rst_n;
    otpb_addr_t  kind;
    logic [3:0]  user_crc;
    logic [3:0]  trace_crc;
    logic [7:0]  cur;

    otpb_crc_if  crc_bus ();

    // Reset release is synchronised; assertion stays asynchronous
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // Walk the writable user array; the device-lock write register lives elsewhere
    assign crc_bus.run  = i_init_complete;
    assign crc_bus.data = st_q.user[crc_bus.idx];

    otpb_crc_walk u_walk (
        .i_clk    (i_clk),
        .i_rst_n  (rst_n),
        .crc_port (crc_bus)
    );

    always_comb begin
        st_d      = st_q;
        kind      = otpb_decode(i_addr);
        user_crc  = OTPB_CRC_SEED;
        trace_crc = OTPB_CRC_SEED;
        cur       = OTPB_ZERO_BYTE;

        for (int i = 0; i < OTPB_USER_BYTES; i++) begin
            user_crc = otpb_crc4_byte(user_crc, st_q.user[i]);
        end
        for (int i = 0; i < OTPB_TRACE_N; i++) begin
            trace_crc = otpb_crc4_byte(trace_crc, st_q.trace[i]);
        end

        // Current content seen by an access; hidden trace bytes read as zero
        case (kind)
            OTPB_A_USER: begin
                cur = i_init_complete ? OTPB_ZERO_BYTE : st_q.user[otpb_user_idx(i_addr)];
            end
            OTPB_A_ULOCK: begin
                cur = st_q.ulock;
            end
            OTPB_A_TRACE: begin
                cur = i_init_complete ? OTPB_ZERO_BYTE
                                      : st_q.trace[otpb_trace_idx(i_addr)];
            end
            OTPB_A_FLOCK: begin
                cur = st_q.flock[otpb_flock_idx(i_addr)];
            end
            default: begin
                cur = OTPB_ZERO_BYTE;
            end
        endcase

        st_d.rsp_valid = i_req;
        if (i_req) begin
            st_d.rsp_data = cur;
            if (i_wr && kind == OTPB_A_USER && !i_init_complete) begin
                // Reserved bits are kept as written; host keeps them zero
                st_d.user[otpb_user_idx(i_addr)] = i_wdata;
                st_d.rsp_data = i_wdata;
            end
        end

        // Factory image arrives from the OTP shadow load only
        if (i_fact_wr) begin
            if (otpb_decode(i_fact_addr) == OTPB_A_TRACE) begin
                st_d.trace[otpb_trace_idx(i_fact_addr)] = i_fact_data;
            end else if (otpb_decode(i_fact_addr) == OTPB_A_FLOCK) begin
                st_d.flock[otpb_flock_idx(i_fact_addr)] = i_fact_data;
            end
        end

        if (i_otp_commit) begin
            st_d.ulock[OTPB_LOCK_BIT]               = 1'b1;
            st_d.ulock[OTPB_ID_MSB:OTPB_ID_LSB]     = OTPB_USER_ID;
            st_d.ulock[OTPB_CRC_MSB:0]              = user_crc;
        end

        st_d.trace_crc = trace_crc;
        st_d.user_err  = st_q.ulock[OTPB_LOCK_BIT] &&
                         (st_q.ulock[OTPB_CRC_MSB:0] != user_crc);

        // First pass after init sets the reference, later passes compare to it
        if (!i_init_complete) begin
            st_d.ref_ok = 1'b0;
        end else if (crc_bus.pass_done) begin
            if (!st_q.ref_ok) begin
                st_d.ref_crc = crc_bus.crc;
                st_d.ref_ok  = 1'b1;
            end else if (crc_bus.crc != st_q.ref_crc) begin
                st_d.arr_err = 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_rsp_valid      = st_q.rsp_valid;
    assign o_rsp_data       = st_q.rsp_data;
    assign o_fact_trace_crc = st_q.trace_crc;
    assign o_user_crc_err   = st_q.user_err;
    assign o_array_crc_err  = st_q.arr_err;

    chk_rsp_always: assert property (@(posedge i_clk) disable iff (!rst_n)
        i_req |=> o_rsp_valid)
        else $error("request without valid response");

    chk_unmapped_zero: assert property (@(posedge i_clk) disable iff (!rst_n)
        i_req && (otpb_decode(i_addr) == OTPB_A_NONE) |=> o_rsp_data == OTPB_ZERO_BYTE)
        else $error("unmapped access returned nonzero data");

    chk_unmapped_wr_still: assert property (@(posedge i_clk) disable iff (!rst_n)
        i_req && i_wr && (otpb_decode(i_addr) == OTPB_A_NONE) && !i_fact_wr && !i_otp_commit
        |=> $stable(st_q.user) && $stable(st_q.ulock) && $stable(st_q.trace))
        else $error("unmapped write changed state");

    chk_ro_write_kept: assert property (@(posedge i_clk) disable iff (!rst_n)
        i_req && i_wr && !i_init_complete && (otpb_decode(i_addr) == OTPB_A_TRACE) && !i_fact_wr
        |=> $stable(st_q.trace) && o_rsp_data == st_q.trace[otpb_trace_idx($past(i_addr))])
        else $error("read-only write not ignored or wrong answer");

    chk_trace_hidden: assert property (@(posedge i_clk) disable iff (!rst_n)
        i_req && i_init_complete && (otpb_decode(i_addr) == OTPB_A_TRACE)
        |=> o_rsp_data == OTPB_ZERO_BYTE)
        else $error("trace byte visible after init complete");

    chk_user_wr_gate: assert property (@(posedge i_clk) disable iff (!rst_n)
        i_req && i_wr && (otpb_decode(i_addr) == OTPB_A_USER)
        |=> st_q.user[otpb_user_idx($past(i_addr))] == ($past(i_init_complete)
            ? $past(st_q.user[otpb_user_idx(i_addr)]) : $past(i_wdata)))
        else $error("user write gating wrong");

    chk_commit_lock: assert property (@(posedge i_clk) disable iff (!rst_n)
        i_otp_commit |=> st_q.ulock[OTPB_LOCK_BIT] &&
        st_q.ulock[OTPB_ID_MSB:OTPB_ID_LSB] == OTPB_USER_ID
        ##1 !o_user_crc_err || $changed(st_q.user))
        else $error("commit did not lock user block consistently");

    chk_ulock_sw_ro: assert property (@(posedge i_clk) disable iff (!rst_n)
        !i_otp_commit |=> $stable(st_q.ulock))
        else $error("user lock register changed without commit");

    chk_err_on_mismatch: assert property (@(posedge i_clk) disable iff (!rst_n)
        i_init_complete && crc_bus.pass_done && st_q.ref_ok && crc_bus.crc != st_q.ref_crc
        |=> o_array_crc_err)
        else $error("array CRC mismatch not flagged");

    // A stuck valid would be taken for a second access by the front end
    chk_rsp_one_shot: assert property (@(posedge i_clk) disable iff (!rst_n)
        !i_req |=> !o_rsp_valid)
        else $error("response valid without request");

    chk_user_read_back: assert property (@(posedge i_clk) disable iff (!rst_n)
        i_req && !i_wr && !i_init_complete && (otpb_decode(i_addr) == OTPB_A_USER)
        |=> o_rsp_data == $past(st_q.user[otpb_user_idx(i_addr)]))
        else $error("user byte read back wrong");

    chk_user_hidden: assert property (@(posedge i_clk) disable iff (!rst_n)
        i_req && i_init_complete && (otpb_decode(i_addr) == OTPB_A_USER)
        |=> o_rsp_data == OTPB_ZERO_BYTE)
        else $error("user byte visible after init complete");

    chk_user_wr_answer: assert property (@(posedge i_clk) disable iff (!rst_n)
        i_req && i_wr && !i_init_complete && (otpb_decode(i_addr) == OTPB_A_USER)
        |=> o_rsp_data == $past(i_wdata))
        else $error("accepted user write not echoed");

    chk_rsvd_read_zero: assert property (@(posedge i_clk) disable iff (!rst_n)
        i_req && (otpb_decode(i_addr) == OTPB_A_RSVD)
        |=> o_rsp_valid && o_rsp_data == OTPB_ZERO_BYTE)
        else $error("reserved address answered wrongly");

    chk_rsvd_wr_still: assert property (@(posedge i_clk) disable iff (!rst_n)
        i_req && i_wr && (otpb_decode(i_addr) == OTPB_A_RSVD) && !i_otp_commit
        |=> $stable(st_q.user) && $stable(st_q.ulock))
        else $error("reserved write disturbed the user block");

    chk_flock_ro: assert property (@(posedge i_clk) disable iff (!rst_n)
        i_req && i_wr && (otpb_decode(i_addr) == OTPB_A_FLOCK) && !i_fact_wr
        |=> $stable(st_q.flock) && o_rsp_data == st_q.flock[otpb_flock_idx($past(i_addr))])
        else $error("factory lock register write not ignored");

    chk_ulock_answer: assert property (@(posedge i_clk) disable iff (!rst_n)
        i_req && (otpb_decode(i_addr) == OTPB_A_ULOCK) && !i_otp_commit
        |=> o_rsp_data == st_q.ulock)
        else $error("user lock register answer is not its content");

    chk_fact_trace_load: assert property (@(posedge i_clk) disable iff (!rst_n)
        i_fact_wr && (otpb_decode(i_fact_addr) == OTPB_A_TRACE)
        |=> st_q.trace[otpb_trace_idx($past(i_fact_addr))] == $past(i_fact_data))
        else $error("factory trace byte not loaded");

    chk_fact_lock_load: assert property (@(posedge i_clk) disable iff (!rst_n)
        i_fact_wr && (otpb_decode(i_fact_addr) == OTPB_A_FLOCK)
        |=> st_q.flock[otpb_flock_idx($past(i_fact_addr))] == $past(i_fact_data))
        else $error("factory lock byte not loaded");

    chk_trace_crc_hold: assert property (@(posedge i_clk) disable iff (!rst_n)
        $stable(st_q.trace) |=> $stable(o_fact_trace_crc))
        else $error("trace CRC moved without a trace change");

    chk_lock_id_user: assert property (@(posedge i_clk) disable iff (!rst_n)
        st_q.ulock[OTPB_LOCK_BIT] |-> st_q.ulock[OTPB_ID_MSB:OTPB_ID_LSB] == OTPB_USER_ID)
        else $error("locked user block carries a foreign identifier");

    chk_user_err_unlocked: assert property (@(posedge i_clk) disable iff (!rst_n)
        !st_q.ulock[OTPB_LOCK_BIT] |=> !o_user_crc_err)
        else $error("user CRC error raised on an unlocked block");

    // Without init the walker stays parked, so no pass can end
    chk_walk_parked: assert property (@(posedge i_clk) disable iff (!rst_n)
        !i_init_complete |=> !crc_bus.pass_done && !st_q.ref_ok)
        else $error("array CRC walk active before init complete");

    chk_ref_capture: assert property (@(posedge i_clk) disable iff (!rst_n)
        i_init_complete && crc_bus.pass_done && !st_q.ref_ok
        |=> st_q.ref_ok && st_q.ref_crc == $past(crc_bus.crc))
        else $error("first pass did not set the CRC reference");

    chk_arr_err_sticky: assert property (@(posedge i_clk) disable iff (!rst_n)
        o_array_crc_err |=> o_array_crc_err)
        else $error("array CRC error dropped before reset");

    chk_arr_err_cause: assert property (@(posedge i_clk) disable iff (!rst_n)
        !o_array_crc_err && !(crc_bus.pass_done && st_q.ref_ok) |=> !o_array_crc_err)
        else $error("array CRC error raised without a mismatching pass");

endmodule

// ### hdl/otpb_crc_if.sv
// Carrier between the bank and its register-array CRC walker.
// Assumes both ends sit on the same clock.
`timescale 1ns/100ps
interface otpb_crc_if;
    logic       run;
    logic [4:0] idx;
    logic [7:0] data;
    logic [3:0] crc;
    logic       pass_done;

    modport walker (input run, input data, output idx, output crc, output pass_done);
    modport owner  (output run, output data, input idx, input crc, input pass_done);
endinterface

// ### hdl/otpb_crc_walk.sv
// Continuous CRC walker: one register byte per clock, a full pass over the array.
// Assumes the owner presents the byte at the requested index in the same cycle.
`timescale 1ns/100ps
module otpb_crc_walk
    import otpb_pkg::*;
(
    input  wire logic   i_clk,
    input  wire logic   i_rst_n,
    otpb_crc_if.walker  crc_port
);

    typedef struct packed {
        logic [4:0] idx;
        logic [3:0] acc;
        logic [3:0] crc;
        logic       done;
        logic [4:0] gap;
    } otpb_walk_t;

    otpb_walk_t st_q;
    otpb_walk_t st_d;
    logic [3:0] acc_next;

    always_comb begin
        st_d     = st_q;
        acc_next = otpb_crc4_byte(st_q.acc, crc_port.data);
        st_d.done = 1'b0;
        if (!crc_port.run) begin
            st_d.idx = 5'h0;
            st_d.acc = OTPB_CRC_SEED;
        end else if (st_q.idx == OTPB_USER_LAST) begin
            st_d.idx  = 5'h0;
            st_d.acc  = OTPB_CRC_SEED;
            st_d.crc  = acc_next;
            st_d.done = 1'b1;
        end else begin
            st_d.idx = st_q.idx + 5'h1;
            st_d.acc = acc_next;
        end
        // Cycles since the pass began; only the pass-length check reads it
        if (!crc_port.run) begin
            st_d.gap = 5'h0;
        end else if (st_q.done) begin
            st_d.gap = 5'h1;
        end else begin
            st_d.gap = st_q.gap + 5'h1;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign crc_port.idx       = st_q.idx;
    assign crc_port.crc       = st_q.crc;
    assign crc_port.pass_done = st_q.done;

    chk_seed_when_idle: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !crc_port.run |=> st_q.acc == OTPB_CRC_SEED && st_q.idx == 5'h0)
        else $error("walker accumulator not reseeded while idle");

    // Counted rather than unrolled: a pass spans one cycle per user byte
    chk_pass_length: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        crc_port.pass_done == (st_q.gap == 5'(OTPB_USER_BYTES)))
        else $error("walker pass length is not one byte per cycle");

endmodule

// ### hdl/otpb_pkg.sv
// Constants, address decode and CRC helpers for the OTP trace, user data and lock bank.
// Assumes byte-wide register accesses on an 8-bit address space.
package otpb_pkg;

    localparam logic [7:0] OTPB_USER_LO_BASE = 8'h40;
    localparam logic [7:0] OTPB_USER_HI_BASE = 8'h50;
    localparam logic [7:0] OTPB_USER_SPAN    = 8'h0f;
    localparam logic [7:0] OTPB_USER_LOCK    = 8'h5f;
    localparam int         OTPB_USER_BYTES   = 30;
    localparam logic [4:0] OTPB_USER_LAST    = 5'h1d;
    localparam int         OTPB_TRACE_N      = 6;
    localparam int         OTPB_FLOCK_N      = 6;

    localparam logic [7:0] OTPB_TRACE_ADDR [OTPB_TRACE_N] = '{8'hca, 8'hcb, 8'hcc, 8'hcd,
                                                              8'hd0, 8'hd1};
    localparam logic [7:0] OTPB_FLOCK_ADDR [OTPB_FLOCK_N] = '{8'haf, 8'hbf, 8'hcf, 8'hdf,
                                                              8'hef, 8'hff};

    localparam int         OTPB_LOCK_BIT   = 7;
    localparam int         OTPB_ID_MSB     = 6;
    localparam int         OTPB_ID_LSB     = 4;
    localparam int         OTPB_CRC_MSB    = 3;
    localparam logic [2:0] OTPB_USER_ID    = 3'h0;
    localparam logic [3:0] OTPB_CRC_POLY   = 4'h9;
    localparam logic [3:0] OTPB_CRC_SEED   = 4'h0;
    localparam logic [7:0] OTPB_ZERO_BYTE  = 8'h00;

    typedef enum logic [2:0] {
        OTPB_A_USER,
        OTPB_A_ULOCK,
        OTPB_A_TRACE,
        OTPB_A_FLOCK,
        OTPB_A_RSVD,
        OTPB_A_NONE
    } otpb_addr_t;

    // x^4 + x^3 + 1, MSB first
    function automatic logic [3:0] otpb_crc4_byte(input logic [3:0] crc, input logic [7:0] b);
        logic [3:0] c;
        logic       fb;
        c = crc;
        for (int i = 7; i >= 0; i--) begin
            fb = c[3] ^ b[i];
            c  = {c[2:0], 1'b0};
            if (fb) begin
                c = c ^ OTPB_CRC_POLY;
            end
        end
        return c;
    endfunction

    function automatic otpb_addr_t otpb_decode(input logic [7:0] a);
        otpb_addr_t k;
        k = OTPB_A_NONE;
        if (a >= OTPB_USER_LO_BASE && a < OTPB_USER_LO_BASE + OTPB_USER_SPAN) begin
            k = OTPB_A_USER;
        end else if (a >= OTPB_USER_HI_BASE && a < OTPB_USER_HI_BASE + OTPB_USER_SPAN) begin
            k = OTPB_A_USER;
        end else if (a == OTPB_USER_LOCK) begin
            k = OTPB_A_ULOCK;
        end else if (a == OTPB_USER_LO_BASE + OTPB_USER_SPAN) begin
            k = OTPB_A_RSVD;
        end else begin
            for (int i = 0; i < OTPB_TRACE_N; i++) begin
                if (a == OTPB_TRACE_ADDR[i]) begin
                    k = OTPB_A_TRACE;
                end
            end
            for (int i = 0; i < OTPB_FLOCK_N; i++) begin
                if (a == OTPB_FLOCK_ADDR[i]) begin
                    k = OTPB_A_FLOCK;
                end
            end
        end
        return k;
    endfunction

    function automatic logic [4:0] otpb_user_idx(input logic [7:0] a);
        logic [7:0] d;
        d = (a >= OTPB_USER_HI_BASE) ? (a - OTPB_USER_HI_BASE + OTPB_USER_SPAN)
                                     : (a - OTPB_USER_LO_BASE);
        return d[4:0];
    endfunction

    function automatic logic [2:0] otpb_trace_idx(input logic [7:0] a);
        logic [2:0] r;
        r = 3'h0;
        for (int i = 0; i < OTPB_TRACE_N; i++) begin
            if (a == OTPB_TRACE_ADDR[i]) begin
                r = 3'(i);
            end
        end
        return r;
    endfunction

    function automatic logic [2:0] otpb_flock_idx(input logic [7:0] a);
        logic [2:0] r;
        r = 3'h0;
        for (int i = 0; i < OTPB_FLOCK_N; i++) begin
            if (a == OTPB_FLOCK_ADDR[i]) begin
                r = 3'(i);
            end
        end
        return r;
    endfunction

endpackage

// ### verification/otpb_host_model.sv
// Host-side partner: issues single-byte register accesses to the bank, collects answers.
// Assumes the bank answers with a one-cycle valid pulse the cycle after the request.
`timescale 1ns/100ps
module otpb_host_model (
    input  wire logic       i_clk,
    output logic            o_req,
    output logic            o_wr,
    output logic [7:0]      o_addr,
    output logic [7:0]      o_wdata,
    input  wire logic       i_rsp_valid,
    input  wire logic [7:0] i_rsp_data
);
    initial begin
        o_req   = 1'b0;
        o_wr    = 1'b0;
        o_addr  = 8'h00;
        o_wdata = 8'h00;
    end

    // Drives on the falling edge so the bank samples settled values on the rising edge
    task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] wdata,
                          output logic [7:0] rdata, output logic ok);
        ok    = 1'b0;
        rdata = 8'h00;
        @(negedge i_clk);
        o_req   = 1'b1;
        o_wr    = wr;
        o_addr  = addr;
        o_wdata = wdata;
        @(negedge i_clk);
        // Released lines show the inverse, so a bank that samples them late sees garbage
        o_req   = 1'b0;
        o_wr    = ~wr;
        o_addr  = ~addr;
        o_wdata = ~wdata;
        for (int i = 0; i < 4 && !ok; i++) begin
            if (i_rsp_valid === 1'b1) begin
                rdata = i_rsp_data;
                ok    = 1'b1;
            end else begin
                @(negedge i_clk);
            end
        end
    endtask
endmodule

// ### verification/tb_otp_trace_userdata_crc_bank.sv
// Self-checking bench for the OTP trace, user data and lock/CRC bank.
// Assumes the bank and the host partner model are compiled before this file.
`timescale 1ns/100ps
`define CHK(what, exp, got) \
    begin \
        n_compared++; \
        if ((got) !== (exp)) begin \
            $display("wrong value %s expected %h seen %h", what, exp, got); \
            n_mismatch++; \
        end \
    end

module tb_otp_trace_userdata_crc_bank;
    typedef struct {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] exp;
    } otpb_row_t;

    logic       clk, rst_n, init_c, req, wr, commit, fwr, rsp_valid, uerr, aerr, ok;
    logic [7:0] addr, wdata, rsp_data, faddr, fdata, rd;
    logic [3:0] ftcrc, c;
    logic [7:0] ub [30];
    logic [7:0] tr [6] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66};
    logic [7:0] ta [6] = '{8'hca, 8'hcb, 8'hcc, 8'hcd, 8'hd0, 8'hd1};
    int         n_mismatch, n_compared;

    otpb_row_t rows [22] = '{
        '{1'b0, 8'hca, 8'h00, 8'h11},
        '{1'b0, 8'hcb, 8'h00, 8'h22},
        '{1'b0, 8'hcc, 8'h00, 8'h33},
        '{1'b0, 8'hcd, 8'h00, 8'h44},
        '{1'b0, 8'hd0, 8'h00, 8'h55},
        '{1'b0, 8'hd1, 8'h00, 8'h66},
        '{1'b1, 8'hca, 8'h5a, 8'h11},
        '{1'b1, 8'hd1, 8'h00, 8'h66},
        '{1'b0, 8'hd1, 8'h00, 8'h66},
        '{1'b0, 8'haf, 8'h00, 8'h9a},
        '{1'b1, 8'haf, 8'h00, 8'h9a},
        '{1'b0, 8'hff, 8'h00, 8'h00},
        '{1'b1, 8'h5f, 8'h8f, 8'h00},
        '{1'b0, 8'h5f, 8'h00, 8'h00},
        '{1'b0, 8'h4f, 8'h00, 8'h00},
        '{1'b1, 8'h4f, 8'h00, 8'h00},
        '{1'b0, 8'h20, 8'h00, 8'h00},
        '{1'b1, 8'h20, 8'h77, 8'h00},
        '{1'b0, 8'h20, 8'h00, 8'h00},
        '{1'b0, 8'hc0, 8'h00, 8'h00},
        '{1'b1, 8'h4e, 8'hc3, 8'hc3},
        '{1'b0, 8'h4e, 8'h00, 8'hc3}
    };

    otpb_bank uut (
        .i_clk           (clk),
        .i_rst_n         (rst_n),
        .i_init_complete (init_c),
        .i_req           (req),
        .i_wr            (wr),
        .i_addr          (addr),
        .i_wdata         (wdata),
        .o_rsp_valid     (rsp_valid),
        .o_rsp_data      (rsp_data),
        .i_otp_commit    (commit),
        .i_fact_wr       (fwr),
        .i_fact_addr     (faddr),
        .i_fact_data     (fdata),
        .o_fact_trace_crc(ftcrc),
        .o_user_crc_err  (uerr),
        .o_array_crc_err (aerr)
    );

    otpb_host_model host (
        .i_clk      (clk),
        .o_req      (req),
        .o_wr       (wr),
        .o_addr     (addr),
        .o_wdata    (wdata),
        .i_rsp_valid(rsp_valid),
        .i_rsp_data (rsp_data)
    );

    always #5 clk = ~clk;

    function automatic logic [3:0] crc_byte(input logic [3:0] cc, input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            cc = {cc[2:0], 1'b0} ^ ((cc[3] ^ b[i]) ? 4'h9 : 4'h0);
        end
        return cc;
    endfunction

    task automatic print_verdict();
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // A lost answer counts against the run and ends it at once
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        host.access(w, a, d, rd, ok);
        if (!ok) begin
            n_mismatch++;
            print_verdict();
        end
    endtask

    task automatic fload(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        fwr   = 1'b1;
        faddr = a;
        fdata = d;
        @(negedge clk);
        fwr   = 1'b0;
        faddr = ~a;
        fdata = ~d;
    endtask

    initial begin
        clk    = 1'b0;
        rst_n  = 1'b0;
        init_c = 1'b0;
        commit = 1'b0;
        fwr    = 1'b0;
        faddr  = 8'h00;
        fdata  = 8'h00;
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        for (int i = 0; i < 6; i++) begin
            fload(ta[i], tr[i]);
        end
        fload(8'haf, 8'h9a);
        foreach (rows[i]) begin
            acc(rows[i].wr, rows[i].addr, rows[i].wdata);
            `CHK("row data", rows[i].exp, rd);
        end
        c = 4'h0;
        for (int i = 0; i < 6; i++) begin
            c = crc_byte(c, tr[i]);
        end
        `CHK("trace crc", c, ftcrc);
        c = 4'h0;
        for (int i = 0; i < 30; i++) begin
            ub[i] = 8'(8'h30 + 7 * i);
            c     = crc_byte(c, ub[i]);
            acc(1'b1, (i < 15) ? 8'(8'h40 + i) : 8'(8'h41 + i), ub[i]);
            `CHK("user write", ub[i], rd);
        end
        @(negedge clk);
        commit = 1'b1;
        @(negedge clk);
        commit = 1'b0;
        acc(1'b0, 8'h5f, 8'h00);
        `CHK("user lock crc", {1'b1, 3'h0, c}, rd);
        repeat (3) @(negedge clk);
        `CHK("user crc err", 1'b0, uerr);
        init_c = 1'b1;
        acc(1'b0, 8'hcb, 8'h00);
        `CHK("hidden trace", 8'h00, rd);
        acc(1'b1, 8'h41, 8'ha5);
        `CHK("locked user write", 8'h00, rd);
        acc(1'b0, 8'haf, 8'h00);
        `CHK("lock after init", 8'h9a, rd);
        repeat (100) @(negedge clk);
        `CHK("array crc err", 1'b0, aerr);
        init_c = 1'b0;
        acc(1'b0, 8'h41, 8'h00);
        `CHK("user kept", ub[1], rd);
        // A changed byte after commit must disagree with the stored lock CRC
        acc(1'b1, 8'h41, ub[1] ^ 8'h01);
        @(negedge clk);
        `CHK("user crc err set", 1'b1, uerr);
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        `CHK("valid in reset", 1'b0, rsp_valid);
        `CHK("user err in reset", 1'b0, uerr);
        `CHK("crc in reset", 4'h0, ftcrc);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        acc(1'b0, 8'h5f, 8'h00);
        `CHK("lock after reset", 8'h00, rd);
        print_verdict();
    end
endmodule
